/* File: hw/spi_nvram_device.sv */
`timescale 1ns/1ps
`include "spi_nvram_params.svh"

module spi_nvram_device #(
  parameter int MEM_WORDS = `MEM_WORDS,
  parameter int ADDR_W    = `MEM_AW
) (
  input  wire logic                  i_clock,
  input  wire logic                  i_rst_b,
  spi_nvram_if.device                link,
  output logic                       o_selected,
  output spi_nvram_pkg::status_byte_t o_status_byte
);
  import spi_nvram_pkg::*;

  localparam int                     NIN       = `SYNC_INPUTS;
  localparam logic [NIN-1:0]         SYNC_INIT = `SYNC_RST;

  // ==========================================================
  // Pin synchronisers
  logic [NIN-1:0]    raw;
  logic [NIN-1:0]    s1_r;
  logic [NIN-1:0]    s2_r;
  logic [NIN-1:0]    s3_r;
  logic [NIN-1:0]    flt_r;

  assign raw = {link.wp_b, link.hold_b, link.si, link.cs_b, link.sck};

  // Three stages; a level counts only once stages two and three agree
  for (genvar g = 0; g < NIN; g++) begin : g_sync
    always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
        s1_r[g]  <= SYNC_INIT[g];
        s2_r[g]  <= SYNC_INIT[g];
        s3_r[g]  <= SYNC_INIT[g];
        flt_r[g] <= SYNC_INIT[g];
      end else begin
        s1_r[g] <= raw[g];
        s2_r[g] <= s1_r[g];
        s3_r[g] <= s2_r[g];
        if (s2_r[g] == s3_r[g]) begin
          flt_r[g] <= s3_r[g];
        end
      end
    end
  end

  // ==========================================================
  // Serial clock edges
  logic              sck_prev_r;
  logic              sck_rise;
  logic              sck_fall;
  logic              active;
  logic              si_f;
  logic              wp_f;

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      sck_prev_r <= SYNC_INIT[`IN_SCK];
    end else begin
      sck_prev_r <= flt_r[`IN_SCK];
    end
  end

  // Edges seen while deselected or on hold are dropped
  assign o_selected = ~flt_r[`IN_CS_B];
  assign active     = o_selected & flt_r[`IN_HOLD_B];
  assign sck_rise   = active & flt_r[`IN_SCK] & ~sck_prev_r;
  assign sck_fall   = active & ~flt_r[`IN_SCK] & sck_prev_r;
  assign si_f       = flt_r[`IN_SI];
  assign wp_f       = flt_r[`IN_WP_B];

  // ==========================================================
  // Command sequencer
  dev_state_t            state_r;
  logic [2:0]            bit_cnt_r;
  logic [7:0]            in_sr_r;
  logic                  addr_second_r;
  logic                  is_read_r;
  logic [ADDR_W-1:0]     addr_r;
  logic [7:0]            byte_in;
  logic                  byte_done;
  logic [ADDR_W-1:0]     addr_shift;
  logic [ADDR_W-1:0]     addr_inc;

  assign byte_in    = {in_sr_r[6:0], si_f};
  assign byte_done  = sck_rise & (bit_cnt_r == `BIT_LAST);
  // Upper address bits beyond the array simply fall off the top
  assign addr_shift = {addr_r[ADDR_W-`BYTE_W-1:0], byte_in};
  assign addr_inc   = ADDR_W'(addr_r + 1'b1);

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      state_r       <= D_OPCODE;
      bit_cnt_r     <= 3'h0;
      in_sr_r       <= 8'h00;
      addr_second_r <= 1'b0;
      is_read_r     <= 1'b0;
      addr_r        <= '0;
    end else if (!o_selected) begin
      state_r       <= D_OPCODE;
      bit_cnt_r     <= 3'h0;
      addr_second_r <= 1'b0;
    end else if (sck_rise) begin
      bit_cnt_r <= 3'(bit_cnt_r + 1'b1);
      in_sr_r   <= byte_in;
      if (byte_done) begin
        case (state_r)
          D_OPCODE: begin
            case (byte_in)
              `OP_STATUS_READ:  state_r <= D_SRD;
              `OP_STATUS_WRITE: state_r <= D_SWR;
              `OP_ARRAY_READ: begin
                state_r   <= D_ADDR;
                is_read_r <= 1'b1;
              end
              `OP_ARRAY_WRITE: begin
                state_r   <= D_ADDR;
                is_read_r <= 1'b0;
              end
              default: state_r <= D_IGNORE;
            endcase
          end
          D_ADDR: begin
            addr_r        <= addr_shift;
            addr_second_r <= 1'b1;
            if (addr_second_r) begin
              state_r <= is_read_r ? D_RDATA : D_WDATA;
            end
          end
          D_WDATA, D_RDATA: addr_r <= addr_inc;
          D_SWR:            state_r <= D_IGNORE;
          default:          state_r <= state_r;
        endcase
      end
    end
  end

  // ==========================================================
  // Status register and write-enable latch
  logic                  guard_en_r;
  logic [2:0]            spare_r;
  logic [1:0]            block_r;
  logic                  wel_r;
  logic                  op_done;
  logic                  status_we;

  assign op_done   = byte_done & (state_r == D_OPCODE);
  // Status write needs the latch, and the guard flag with pin low blocks it
  assign status_we = byte_done & (state_r == D_SWR) & wel_r
                   & ~(guard_en_r & ~wp_f);

  assign o_status_byte = {guard_en_r, spare_r, block_r, wel_r, 1'b0};

  // Nonvolatile bits: reset models the factory content
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      {guard_en_r, spare_r, block_r} <= `ST_NV_RST;
    end else if (status_we) begin
      guard_en_r <= byte_in[`ST_GUARD_BIT];
      spare_r    <= byte_in[`ST_SPARE_HI:`ST_SPARE_LO];
      block_r    <= byte_in[`ST_BLOCK_HI_BIT:`ST_BLOCK_LO_BIT];
    end
  end

  // Latch: only the two latch commands touch it
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      wel_r <= 1'b0;
    end else if (op_done && byte_in == `OP_CLEAR_LATCH) begin
      wel_r <= 1'b0;
    end else if (op_done && byte_in == `OP_SET_LATCH) begin
      wel_r <= 1'b1;
    end
  end

  // ==========================================================
  // Array storage
  logic [7:0]            mem_r [MEM_WORDS];
  logic                  guarded;
  logic                  mem_we;

  // Guarded region chosen by the two block bits
  always_comb begin
    case (block_r)
      `GUARD_NONE:    guarded = 1'b0;
      `GUARD_QUARTER: guarded = (addr_r >= `GUARD_QUARTER_BASE);
      `GUARD_HALF:    guarded = (addr_r >= `GUARD_HALF_BASE);
      default:        guarded = 1'b1;
    endcase
  end

  assign mem_we = byte_done & (state_r == D_WDATA) & wel_r & ~guarded;

  // Write lands on the last data bit; nothing to poll afterwards
  always_ff @(posedge i_clock) begin
    if (mem_we) begin
      mem_r[addr_r] <= byte_in;
    end
  end

  // ==========================================================
  // Output shifter
  logic [7:0]            out_sr_r;
  logic                  so_r;
  logic                  reading;

  assign reading = (state_r == D_SRD) | (state_r == D_RDATA);

  // Reload on the last rising edge so the next falling edge shows bit 7
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      out_sr_r <= 8'h00;
      so_r     <= 1'b0;
    end else if (byte_done) begin
      if ((op_done && byte_in == `OP_STATUS_READ) || state_r == D_SRD) begin
        out_sr_r <= o_status_byte;
      end else if (state_r == D_ADDR && addr_second_r && is_read_r) begin
        out_sr_r <= mem_r[addr_shift];
      end else if (state_r == D_RDATA) begin
        out_sr_r <= mem_r[addr_inc];
      end
    end else if (sck_fall && reading) begin
      so_r     <= out_sr_r[7];
      out_sr_r <= {out_sr_r[6:0], 1'b0};
    end
  end

  // Drive only while selected, not on hold, and in a read phase
  assign link.so    = so_r;
  assign link.so_oe = active & reading;
endmodule : spi_nvram_device

/* File: hw/spi_nvram_host.sv */
`timescale 1ns/1ps
`include "spi_nvram_params.svh"

module spi_nvram_host #(
  parameter int HALF   = `HALF_CYCLES,
  parameter int AW     = 8
) (
  input  wire logic          i_clock,
  input  wire logic          i_rst_b,
  input  wire logic          i_psel,
  input  wire logic          i_penable,
  input  wire logic          i_pwrite,
  input  wire logic [AW-1:0] i_paddr,
  input  wire logic [31:0]   i_pwdata,
  output logic      [31:0]   o_prdata,
  output logic               o_pready,
  output logic               o_pslverr,
  spi_nvram_if.host          link
);
  import spi_nvram_pkg::*;

  // ==========================================================
  // Return line synchroniser
  logic              m1_r;
  logic              m2_r;
  logic              m3_r;
  logic              miso_r;

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      m1_r   <= 1'b1;
      m2_r   <= 1'b1;
      m3_r   <= 1'b1;
      miso_r <= 1'b1;
    end else begin
      m1_r <= link.so_line;
      m2_r <= m1_r;
      m3_r <= m2_r;
      if (m2_r == m3_r) begin
        miso_r <= m3_r;
      end
    end
  end

  // ==========================================================
  // APB slave
  host_state_t       state_r;
  logic [2:0]        cfg_r;
  logic [8:0]        tx_r;
  logic [7:0]        rx_r;
  logic              busy;
  logic              hold_on;
  logic              freeze;
  logic [3:0]        resume_r;
  logic              mapped;
  logic              tx_hit;
  logic              start;
  logic              cfg_we;
  logic [31:0]       rd_mux;

  // The settle window after a hold counts as busy; the hold itself does not, so a byte start while held and idle is lost
  assign busy   = (state_r != H_IDLE) | ((resume_r != 4'h0) & ~hold_on);
  assign tx_hit = i_psel & i_pwrite & (i_paddr == AW'(`REG_TX));
  assign mapped = (i_paddr == AW'(`REG_CONFIG)) | (i_paddr == AW'(`REG_TX))
                | (i_paddr == AW'(`REG_RX)) | (i_paddr == AW'(`REG_STATUS));
  // Byte writes stall in the access phase while a byte is in flight
  assign o_pready  = ~(tx_hit & busy);
  assign o_pslverr = i_psel & i_penable & ~mapped;
  assign start     = tx_hit & i_penable & ~busy;
  assign cfg_we    = i_psel & i_penable & i_pwrite & (i_paddr == AW'(`REG_CONFIG));

  always_comb begin
    case (i_paddr)
      AW'(`REG_CONFIG): rd_mux = {29'h0, cfg_r};
      AW'(`REG_TX):     rd_mux = {23'h0, tx_r};
      AW'(`REG_RX):     rd_mux = {24'h0, rx_r};
      AW'(`REG_STATUS): rd_mux = {30'h0, ~link.cs_b, busy};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup cycle, shown in the access phase
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable) begin
      o_prdata <= rd_mux;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      cfg_r <= `CFG_RST;
    end else if (cfg_we) begin
      cfg_r <= i_pwdata[2:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      tx_r <= 9'h000;
    end else if (start) begin
      tx_r <= i_pwdata[8:0];
    end
  end

  // ==========================================================
  // Byte engine: serial clock from a divider
  logic [7:0]        div_r;
  logic [2:0]        bit_cnt_r;
  logic [7:0]        tx_sr_r;
  logic [7:0]        rx_sr_r;
  logic              sck_r;
  logic              cs_b_r;
  logic              mosi_r;
  logic              tick;
  logic [7:0]        rx_next;

  // Half period never shorter than the 10 MHz limit allows
  localparam int     HALF_USE = (HALF > `HALF_MIN) ? HALF : `HALF_MIN;
  assign hold_on = cfg_r[`CFG_HOLD_BIT];
  assign tick    = (div_r == 8'(HALF_USE - 1));
  assign rx_next = {rx_sr_r[6:0], miso_r};
  // Freeze on the very edge that sets hold, so no clock edge meets it
  assign freeze  = hold_on | (cfg_we & i_pwdata[`CFG_HOLD_BIT]) | (resume_r != 4'h0);

  // After a hold the far end needs its sync round trip before edges count
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      resume_r <= 4'h0;
    end else if (hold_on) begin
      resume_r <= `RESUME_CYCLES;
    end else if (resume_r != 4'h0) begin
      resume_r <= 4'(resume_r - 1'b1);
    end
  end

  // Hold freezes everything, select included, so no edge escapes
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      state_r   <= H_IDLE;
      div_r     <= 8'h00;
      bit_cnt_r <= 3'h0;
      tx_sr_r   <= 8'h00;
      rx_sr_r   <= 8'h00;
      rx_r      <= 8'h00;
      sck_r     <= 1'b0;
      cs_b_r    <= 1'b1;
      mosi_r    <= 1'b0;
    end else if (!freeze) begin
      div_r <= tick ? 8'h00 : 8'(div_r + 1'b1);
      case (state_r)
        H_IDLE: begin
          sck_r <= cfg_r[`CFG_MODE3_BIT];
          div_r <= 8'h00;
          if (start) begin
            cs_b_r    <= 1'b0;
            tx_sr_r   <= i_pwdata[7:0];
            bit_cnt_r <= 3'h0;
            state_r   <= H_LEAD;
          end
        end
        H_LEAD: if (tick) begin
          sck_r   <= 1'b0;
          mosi_r  <= tx_sr_r[7];
          state_r <= H_LOW;
        end
        H_LOW: if (tick) begin
          sck_r   <= 1'b1;
          state_r <= H_HIGH;
        end
        H_HIGH: if (tick) begin
          rx_sr_r <= rx_next;
          if (bit_cnt_r == `BIT_LAST) begin
            rx_r    <= rx_next;
            sck_r   <= cfg_r[`CFG_MODE3_BIT];
            state_r <= tx_r[`TX_END_BIT] ? H_END : H_IDLE;
          end else begin
            bit_cnt_r <= 3'(bit_cnt_r + 1'b1);
            sck_r     <= 1'b0;
            mosi_r    <= tx_sr_r[6];
            tx_sr_r   <= {tx_sr_r[6:0], 1'b0};
            state_r   <= H_LOW;
          end
        end
        H_END: if (tick) begin
          cs_b_r  <= 1'b1;
          state_r <= H_IDLE;
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  // Separate data lines; a shared line would also do
  assign link.sck    = sck_r;
  assign link.cs_b   = cs_b_r;
  assign link.si     = mosi_r;
  assign link.hold_b = ~hold_on;
  assign link.wp_b   = cfg_r[`CFG_WP_BIT];
endmodule : spi_nvram_host

/* File: hw/spi_nvram_if.sv */
`timescale 1ns/1ps
interface spi_nvram_if;
  logic sck;
  logic cs_b;
  logic si;
  logic so;
  logic so_oe;
  logic hold_b;
  logic wp_b;
  logic so_line;

  // Undriven output line reads high, as with a pull-up
  assign so_line = so_oe ? so : 1'b1;

  modport device (input sck, input cs_b, input si, input hold_b, input wp_b,
                  output so, output so_oe);
  modport host   (output sck, output cs_b, output si, output hold_b, output wp_b,
                  input so_line);
endinterface : spi_nvram_if

/* File: hw/spi_nvram_params.svh */
`ifndef SPI_NVRAM_PARAMS_SVH
`define SPI_NVRAM_PARAMS_SVH

// ==========================================================
// Command codes
`define OP_SET_LATCH      8'h06
`define OP_CLEAR_LATCH    8'h04
`define OP_STATUS_READ    8'h05
`define OP_STATUS_WRITE   8'h01
`define OP_ARRAY_READ     8'h03
`define OP_ARRAY_WRITE    8'h02

// ==========================================================
// Status byte layout and reset
`define ST_GUARD_BIT      7
`define ST_SPARE_HI       6
`define ST_SPARE_LO       4
`define ST_BLOCK_HI_BIT   3
`define ST_BLOCK_LO_BIT   2
`define ST_NV_RST         6'h00
`define GUARD_NONE        2'h0
`define GUARD_QUARTER     2'h1
`define GUARD_HALF        2'h2

// ==========================================================
// Array geometry and guarded region bases
`define MEM_WORDS         8192
`define MEM_AW            13
`define GUARD_QUARTER_BASE 13'h1800
`define GUARD_HALF_BASE   13'h1000
`define BYTE_W            8
`define BIT_LAST          3'h7

// ==========================================================
// Pin synchroniser: {wp_b, hold_b, si, cs_b, sck}
`define SYNC_INPUTS       5
`define SYNC_RST          5'h1A
`define IN_SCK            0
`define IN_CS_B           1
`define IN_SI             2
`define IN_HOLD_B         3
`define IN_WP_B           4

// ==========================================================
// Controller register map (APB byte addresses) and fields
`define REG_CONFIG        8'h00
`define REG_TX            8'h04
`define REG_RX            8'h08
`define REG_STATUS        8'h0C
`define CFG_MODE3_BIT     0
`define CFG_WP_BIT        1
`define CFG_HOLD_BIT      2
`define CFG_RST           3'h2
`define TX_END_BIT        8
`define STAT_BUSY_BIT     0
`define STAT_SEL_BIT      1

// ==========================================================
// Link timing: 50 MHz clock, serial clock at most 10 MHz
`define CLOCK_HZ          50000000
`define SCK_MAX_HZ        10000000
`define HALF_MIN          ((`CLOCK_HZ + 2 * `SCK_MAX_HZ - 1) / (2 * `SCK_MAX_HZ))
`define HALF_CYCLES       8
`define RESUME_CYCLES     4'hA

`endif

/* File: hw/spi_nvram_pkg.sv */
package spi_nvram_pkg;
  typedef logic [7:0] status_byte_t;
  typedef enum logic [2:0] {
    D_OPCODE, D_ADDR, D_WDATA, D_RDATA, D_SRD, D_SWR, D_IGNORE
  } dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE, H_LEAD, H_LOW, H_HIGH, H_END
  } host_state_t;
endpackage : spi_nvram_pkg

/* File: tb/spi_nvram_assertions.sv */
`timescale 1ns/1ps
// ====================
// Link protocol checker
module spi_nvram_assertions (
  input wire logic                         i_clock,
  input wire logic                         i_rst_b,
  input wire logic                         sck,
  input wire logic                         cs_b,
  input wire logic                         si,
  input wire logic                         so,
  input wire logic                         so_oe,
  input wire logic                         hold_b,
  input wire logic                         wp_b,
  input wire spi_nvram_pkg::status_byte_t  o_status_byte
);
  import spi_nvram_pkg::*;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  // ====================
  // Assertions; sync latency is at most 5 clocks
  chk_desel_float: assert property (cs_b [*5] |-> !so_oe)
    else $error("output driven while deselected");
  chk_hold_float: assert property (!hold_b [*5] |-> !so_oe)
    else $error("output driven during hold");
  chk_hold_keeps_sel: assert property (!hold_b && $past(!hold_b) |-> $stable(cs_b))
    else $error("select moved during hold");
  chk_bit_zero: assert property (o_status_byte[0] == 1'b0)
    else $error("status bit 0 not zero");
  chk_so_after_fall: assert property (so_oe && $past(so_oe) && $changed(so)
    |-> !$past(sck, 1) && !$past(sck, 3))
    else $error("output changed outside clock low phase");
  chk_status_only_sel: assert property ($changed(o_status_byte) |-> !$past(cs_b))
    else $error("status changed while deselected");
  chk_lead_before_clk: assert property ($fell(cs_b) |-> $stable(sck) [*7])
    else $error("clock moved too soon after select");
  chk_si_on_low: assert property ($changed(si) && !cs_b |-> !sck)
    else $error("data input changed with clock high");
  chk_sck_high_len: assert property ($rose(sck) |-> sck [*8])
    else $error("clock high phase too short");
  chk_wp_in_frame: assert property (!cs_b && $past(!cs_b) |-> $stable(wp_b))
    else $error("protect pin moved inside a frame");

  // Main scenarios reached
  cov_read_out: cover property (!cs_b && so_oe);
  cov_hold: cover property (!hold_b && !cs_b);
  cov_mode3: cover property ($fell(cs_b) && sck);
endmodule : spi_nvram_assertions

/* File: tb/test_serial_nvram_slave_port.sv */
`timescale 1ns/1ps
`include "spi_nvram_params.svh"
module test_serial_nvram_slave_port;
  import spi_nvram_pkg::*;
  logic         i_clock, i_rst_b, psel, penable, pwrite, pready, pslverr, err, sel;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  status_byte_t st;
  int           n_fail, samples_checked;

  spi_nvram_if link_if ();
  spi_nvram_host spi_nvram_host_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(link_if.host));
  spi_nvram_device spi_nvram_device_i (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .link(link_if.device), .o_selected(sel), .o_status_byte(st));
  spi_nvram_assertions spi_nvram_assertions_i (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .sck(link_if.sck), .cs_b(link_if.cs_b), .si(link_if.si), .so(link_if.so),
    .so_oe(link_if.so_oe), .hold_b(link_if.hold_b), .wp_b(link_if.wp_b),
    .o_status_byte(st));

  // ====================
  // Clock, 20 ns period
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task finish_test();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // ====================
  // APB master; pready, prdata and pslverr taken at the completing edge
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge i_clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      n_fail++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Poll busy under a bound, then fetch the received byte
  task wait_idle();
    int n;
    n = 0;
    do begin
      apb(`REG_STATUS, 1'b0, 32'h0);
      n++;
    end while (rd[`STAT_BUSY_BIT] !== 1'b0 && n < 200);
    if (n >= 200) begin
      n_fail++;
      finish_test();
    end
    apb(`REG_RX, 1'b0, 32'h0);
  endtask : wait_idle

  task xfer(input logic [7:0] b, input logic last);
    apb(`REG_TX, 1'b1, {23'h0, last, b});
    wait_idle();
  endtask : xfer

  task status_wr(input logic [7:0] v);
    xfer(`OP_STATUS_WRITE, 1'b0);
    xfer(v, 1'b1);
  endtask : status_wr

  // Address high byte first, top bits zero
  task arr(input logic [7:0] op, input logic [12:0] a, input logic [7:0] v);
    xfer(op, 1'b0);
    xfer({3'h0, a[12:8]}, 1'b0);
    xfer(a[7:0], 1'b0);
    xfer(v, 1'b1);
  endtask : arr

  // ====================
  // Main sequence
  initial begin
    i_rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; n_fail = 0; samples_checked = 0;
    repeat (5) @(posedge i_clock);
    i_rst_b <= 1'b1;
    check(st, 8'h00);
    apb(`REG_CONFIG, 1'b0, 32'h0);
    check(rd, 32'h2);
    apb(8'h10, 1'b0, 32'h0);
    check({rd[30:0], err}, 32'h1);
    xfer(`OP_STATUS_READ, 1'b0);
    xfer(8'hFF, 1'b1);
    check(rd, 32'h0);
    xfer(`OP_SET_LATCH, 1'b1);
    check(st, 8'h02);
    status_wr(8'hFF);
    check(st, 8'hFE);
    xfer(`OP_STATUS_READ, 1'b0);
    xfer(8'h00, 1'b0);
    check(rd, 32'hFE);
    xfer(8'h00, 1'b1);
    check(rd, 32'hFE);
    // Guard flag set and pin low: status write must bounce
    apb(`REG_CONFIG, 1'b1, 32'h0);
    status_wr(8'h00);
    check(st, 8'hFE);
    apb(`REG_CONFIG, 1'b1, 32'h2);
    status_wr(8'h00);
    check(st, 8'h02);
    arr(`OP_ARRAY_WRITE, 13'h17FF, 8'h3C);
    arr(`OP_ARRAY_WRITE, 13'h1800, 8'h5A);
    arr(`OP_ARRAY_WRITE, 13'h1000, 8'h22);
    // Upper half guarded: 0FFF takes the write, 1000 keeps its old byte
    status_wr(8'h08);
    check(st, 8'h0A);
    arr(`OP_ARRAY_WRITE, 13'h0FFF, 8'h11);
    arr(`OP_ARRAY_WRITE, 13'h1000, 8'h99);
    // One read across the half boundary, address stepping by one
    xfer(`OP_ARRAY_READ, 1'b0);
    xfer(8'h0F, 1'b0);
    xfer(8'hFF, 1'b0);
    xfer(8'h00, 1'b0);
    check(rd, 32'h11);
    xfer(8'h00, 1'b1);
    check(rd, 32'h22);
    status_wr(8'h74);
    check(st, 8'h76);
    arr(`OP_ARRAY_WRITE, 13'h17FF, 8'hC3);
    arr(`OP_ARRAY_WRITE, 13'h1800, 8'hC3);
    arr(`OP_ARRAY_READ, 13'h17FF, 8'h00);
    check(rd, 32'hC3);
    arr(`OP_ARRAY_READ, 13'h1800, 8'h00);
    check(rd, 32'h5A);
    xfer(`OP_CLEAR_LATCH, 1'b1);
    check(st, 8'h74);
    status_wr(8'h00);
    check(st, 8'h74);
    apb(`REG_CONFIG, 1'b1, 32'h3);
    xfer(`OP_STATUS_READ, 1'b0);
    xfer(8'h00, 1'b1);
    check(rd, 32'h74);
    // Hold mid-byte, clock high: output floats, select stays, byte resumes
    apb(`REG_CONFIG, 1'b1, 32'h2);
    xfer(`OP_STATUS_READ, 1'b0);
    apb(`REG_TX, 1'b1, {23'h0, 1'b1, 8'h00});
    repeat (48) @(posedge i_clock);
    check(link_if.so_oe, 1'b1);
    apb(`REG_CONFIG, 1'b1, 32'h6);
    repeat (40) @(posedge i_clock);
    check(link_if.so_oe, 1'b0);
    apb(`REG_STATUS, 1'b0, 32'h0);
    check(rd, 32'h3);
    apb(`REG_CONFIG, 1'b1, 32'h2);
    wait_idle();
    check(rd, 32'h74);
    check(sel, 1'b0);
    finish_test();
  end
endmodule : test_serial_nvram_slave_port
